//--- core/rsspi_pkg.sv
// shared constants and types for the radar sensor serial slave port
// assumes 8-bit words, msb first, mode 0 framing on the serial link
package rsspi_pkg;

  localparam int unsigned WORD_W   = 8;
  localparam logic [2:0]  BIT_LAST = 3'h7;
  localparam logic [7:0]  TX_RST   = 8'h00;
  localparam logic [7:0]  CNT_RST  = 8'h00;

  typedef logic [WORD_W-1:0] rsspi_word_t;

  // serial pins seen by the device, miso as a three-state pin
  typedef struct packed {
    logic ss_n;
    logic mosi;
  } rsspi_pin_in_s;

  typedef struct packed {
    logic miso;
    logic miso_oe;
  } rsspi_pin_out_s;

  // word handed across the clock crossing
  typedef struct packed {
    rsspi_word_t word;
    logic        tgl;
  } rsspi_xfer_s;

  // whole state of the system-clock side
  typedef struct packed {
    logic        ss_s1;
    logic        ss_s2;
    logic        ss_prev;
    logic        tg_s1;
    logic        tg_s2;
    logic        tg_prev;
    rsspi_word_t rx_data;
    logic        rx_valid;
    rsspi_word_t tx_word;
    logic        frame_done;
    logic        frame_active;
    logic [7:0]  word_cnt;
  } rsspi_state_s;

endpackage

//--- core/rsspi_link.sv
// serial-clock side of the sensor slave port: receive shifter and bit counters
// assumes the host clock only toggles while select is low; select high
// clears the counters asynchronously since no clock edge may follow
`timescale 1ns/1ps
module rsspi_link (
  // serial link
  input  wire logic                     i_sclk,
  input  wire rsspi_pkg::rsspi_pin_in_s i_pins,
  output rsspi_pkg::rsspi_pin_out_s     o_pins,
  // system side
  input  wire logic                     i_rst_n,
  input  wire rsspi_pkg::rsspi_word_t   i_tx_word,
  output rsspi_pkg::rsspi_xfer_s        o_xfer
);
  import rsspi_pkg::*;

  logic [2:0]  rcnt_q;
  logic [2:0]  fcnt_q;
  rsspi_word_t shin_q;
  rsspi_xfer_s xfer_q;

  // rising edge: sample mosi, partial word dropped on deselect
  always_ff @(posedge i_sclk or posedge i_pins.ss_n) begin
    if (i_pins.ss_n) begin
      rcnt_q <= 3'h0;
      shin_q <= TX_RST;
    end else begin
      rcnt_q <= rcnt_q + 3'h1;
      shin_q <= {shin_q[WORD_W-2:0], i_pins.mosi};
    end
  end

  // completed word held and flagged by toggle; survives deselect
  always_ff @(posedge i_sclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      xfer_q <= '0;
    end else if (!i_pins.ss_n && rcnt_q == BIT_LAST) begin
      xfer_q.word <= {shin_q[WORD_W-2:0], i_pins.mosi};
      xfer_q.tgl  <= ~xfer_q.tgl;
    end
  end

  // falling edge: advance output bit index only
  always_ff @(negedge i_sclk or posedge i_pins.ss_n) begin
    if (i_pins.ss_n) begin
      fcnt_q <= 3'h0;
    end else begin
      fcnt_q <= fcnt_q + 3'h1;
    end
  end

  // msb must be on the wire before the first rising edge
  assign o_pins.miso    = i_tx_word[BIT_LAST - fcnt_q] & ~i_pins.ss_n;
  assign o_pins.miso_oe = ~i_pins.ss_n;
  assign o_xfer         = xfer_q;

  AST_RX_TOGGLE: assert property (@(posedge i_sclk) disable iff (i_pins.ss_n)
    rcnt_q == BIT_LAST |=> xfer_q.tgl != $past(xfer_q.tgl))
    else $error("word toggle missing after eighth rising edge");

endmodule // rsspi_link

//--- core/rsspi_slave.sv
// radar sensor serial slave port, top level on the system clock
// assumes the host runs mode 0 with its own select, 8-bit words msb first
`timescale 1ns/1ps
module rsspi_slave (
  // system clock and reset
  input  wire logic                     i_clk,
  input  wire logic                     i_rst_n,
  // serial link
  input  wire logic                     i_sclk,
  input  wire rsspi_pkg::rsspi_pin_in_s i_pins,
  output rsspi_pkg::rsspi_pin_out_s     o_pins,
  // received words
  output rsspi_pkg::rsspi_word_t        o_rx_data,
  output logic                          o_rx_valid,
  // word to send
  input  wire rsspi_pkg::rsspi_word_t   i_tx_data,
  input  wire logic                     i_tx_valid,
  output logic                          o_tx_ready,
  // frame status
  output logic                          o_frame_active,
  output logic                          o_frame_done,
  output logic [7:0]                    o_word_cnt
);
  import rsspi_pkg::*;

  rsspi_state_s q;
  rsspi_state_s d;
  rsspi_xfer_s  xfer;
  logic         tx_take;
  logic         rx_event;

  rsspi_link u_link (
    .i_sclk    (i_sclk),
    .i_pins    (i_pins),
    .o_pins    (o_pins),
    .i_rst_n   (i_rst_n),
    .i_tx_word (q.tx_word),
    .o_xfer    (xfer)
  );

  // tx word may only change while deselected for two synced cycles;
  // the link reads it directly, so it must be static through a frame.
  // limitation: one tx word per frame, repeated for every word in it
  assign o_tx_ready = q.ss_s2 & q.ss_prev;
  assign tx_take    = i_tx_valid & o_tx_ready;
  assign rx_event   = q.tg_s2 ^ q.tg_prev;

  always_comb begin
    d            = q;
    d.ss_s1      = i_pins.ss_n;
    d.ss_s2      = q.ss_s1;
    d.ss_prev    = q.ss_s2;
    d.tg_s1      = xfer.tgl;
    d.tg_s2      = q.tg_s1;
    d.tg_prev    = q.tg_s2;
    d.rx_valid   = 1'b0;
    d.frame_done = 1'b0;
    // held word is stable for 8 serial clocks after its toggle
    if (rx_event) begin
      d.rx_data  = xfer.word;
      d.rx_valid = 1'b1;
    end
    if (tx_take) begin
      d.tx_word = i_tx_data;
    end
    d.frame_active = ~q.ss_s2;
    if (q.ss_s2 && !q.ss_prev) begin
      d.frame_done = 1'b1;
    end
    if (!q.ss_s2 && q.ss_prev) begin
      d.word_cnt = CNT_RST;
    end else if (rx_event) begin
      d.word_cnt = q.word_cnt + 8'h01;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      q          <= '0;
      q.ss_s1    <= 1'b1;
      q.ss_s2    <= 1'b1;
      q.ss_prev  <= 1'b1;
      q.tx_word  <= TX_RST;
      q.word_cnt <= CNT_RST;
    end else begin
      q <= d;
    end
  end

  assign o_rx_data      = q.rx_data;
  assign o_rx_valid     = q.rx_valid;
  assign o_frame_active = q.frame_active;
  assign o_frame_done   = q.frame_done;
  assign o_word_cnt     = q.word_cnt;

  AST_RX_PULSE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_rx_valid |=> !o_rx_valid)
    else $error("rx valid held longer than one cycle");

  AST_RX_CAUSE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    rx_event |=> o_rx_valid && o_rx_data == $past(xfer.word))
    else $error("received word not delivered one cycle after toggle");

  AST_TX_LOAD: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    tx_take |=> q.tx_word == $past(i_tx_data))
    else $error("tx word not loaded");

  AST_TX_HOLD: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !o_tx_ready |=> $stable(q.tx_word))
    else $error("tx word changed during a frame");

  AST_FRAME_END: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(q.ss_s2) |=> o_frame_done ##1 !o_frame_done)
    else $error("frame end pulse wrong");

  AST_CNT_CLEAR: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $fell(q.ss_s2) |=> o_word_cnt == CNT_RST)
    else $error("word count not cleared at frame start");

  AST_ACTIVE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $fell(q.ss_s2) |=> o_frame_active [*1] ##0 !o_tx_ready)
    else $error("frame not marked active after select");

  // status flags must agree with the synced select history
  AST_RDY_IDLE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_tx_ready |-> !o_frame_active)
    else $error("tx ready while frame active");

  AST_ACT_MATCH: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_frame_active == !q.ss_prev)
    else $error("frame active does not follow select");

  AST_ACT_RISE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(o_frame_active) |-> $past(!q.ss_s2))
    else $error("frame active rose without select");

  AST_DONE_CAUSE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_frame_done |-> $past(q.ss_s2) && !$past(q.ss_prev))
    else $error("frame done without select release");

  AST_DONE_IDLE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_frame_done |-> !o_frame_active)
    else $error("frame done while frame active");

  AST_DONE_PULSE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_frame_done |=> !o_frame_done)
    else $error("frame done held longer than one cycle");

  AST_RX_ONLY: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_rx_valid |-> $past(rx_event))
    else $error("rx valid without a received word");

  AST_RX_DATA_HOLD: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !rx_event |=> $stable(o_rx_data))
    else $error("rx data changed without a word");

  // words are eight serial clocks apart, far more than one system cycle
  AST_EVENT_GAP: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    rx_event |=> !rx_event)
    else $error("two word events in adjacent cycles");

  AST_CNT_STEP: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    rx_event && !(!q.ss_s2 && q.ss_prev)
    |=> o_word_cnt == $past(o_word_cnt) + 8'h01)
    else $error("word count did not advance");

  AST_CNT_HOLD: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !rx_event && !(!q.ss_s2 && q.ss_prev) |=> $stable(o_word_cnt))
    else $error("word count changed without cause");

  AST_READY_LOW: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !q.ss_s2 |-> !o_tx_ready)
    else $error("tx ready while synced select low");

  AST_READY_HIGH: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    q.ss_s2 && q.ss_prev |-> o_tx_ready)
    else $error("tx ready missing while deselected");

  AST_TX_CAUSE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $changed(q.tx_word) |-> $past(tx_take))
    else $error("tx word changed without a load");

  // pin checks sampled on the system clock; both follow select directly
  AST_OE_PIN: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_pins.miso_oe == !i_pins.ss_n)
    else $error("miso enable does not follow select");

  AST_MISO_OFF: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !o_pins.miso_oe |-> !o_pins.miso)
    else $error("miso driven high while released");

  AST_RX_VALID_DATA: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_rx_valid |-> o_rx_data == $past(xfer.word))
    else $error("rx data not the held word");

endmodule // rsspi_slave

//--- verif/rsspi_host.sv
// host master model for the sensor serial port, mode 0
// assumes it is the only master and owns this slave's select
`timescale 1ns/1ps
module rsspi_host #(
  parameter int HALF = 80
) (
  // serial link
  output logic                     o_sclk,
  output rsspi_pkg::rsspi_pin_in_s o_pins,
  input  wire logic                i_miso
);
  import rsspi_pkg::*;
  initial begin
    o_sclk = 1'b0;
    o_pins = '{ss_n: 1'b1, mosi: 1'b0};
  end
  // n bits msb first from d; miso gathered into q
  task automatic frame(input logic [15:0] d, input int n,
                       output logic [15:0] q);
    q = 16'h0000;
    o_pins.ss_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      o_pins.mosi = d[15-i];
      #HALF o_sclk = 1'b1;
      q = {q[14:0], i_miso};
      #HALF o_sclk = 1'b0;
    end
    #HALF o_pins.ss_n = 1'b1;
    o_pins.mosi = ~o_pins.mosi;
    #HALF;
  endtask
  // clocks with select high, only when a test asks for bus noise
  task automatic noise();
    for (int i = 0; i < 8; i++) begin
      o_pins.mosi = i[0];
      #HALF o_sclk = 1'b1;
      #HALF o_sclk = 1'b0;
    end
  endtask
endmodule // rsspi_host

//--- verif/rsspi_slave_tb_top.sv
// self-checking bench for the sensor serial slave port
// assumes the host model drives the link in its own clock domain
`timescale 1ns/1ps
module rsspi_slave_tb_top;
  import rsspi_pkg::*;
  logic           i_clk = 1'b0;
  logic           i_rst_n = 1'b0;
  logic           sclk;
  rsspi_pin_in_s  pins_in;
  rsspi_pin_out_s pins_out;
  rsspi_word_t    rx_data, tx_data;
  logic           rx_valid, tx_valid, tx_ready, frame_done;
  logic           frame_active;
  logic [7:0]     word_cnt;
  logic [15:0]    q;
  rsspi_word_t    rxw[$];
  int             error_cnt = 0, check_count = 0, done_n = 0;

  always #5 i_clk = ~i_clk;

  rsspi_host host (.o_sclk(sclk), .o_pins(pins_in), .i_miso(pins_out.miso));
  rsspi_slave DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_sclk(sclk),
    .i_pins(pins_in), .o_pins(pins_out), .o_rx_data(rx_data),
    .o_rx_valid(rx_valid), .i_tx_data(tx_data), .i_tx_valid(tx_valid),
    .o_tx_ready(tx_ready), .o_frame_active(frame_active),
    .o_frame_done(frame_done),
    .o_word_cnt(word_cnt));

  always @(posedge i_clk) begin
    if (rx_valid === 1'b1) rxw.push_back(rx_data);
    if (frame_done === 1'b1) done_n++;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic load(input rsspi_word_t w);
    @(negedge i_clk);
    chk(tx_ready, 1'b1);
    tx_data = w;
    tx_valid = 1'b1;
    @(negedge i_clk) tx_valid = 1'b0;
    repeat (2) @(negedge i_clk);
  endtask
  task automatic settle();
    repeat (12) @(negedge i_clk);
    rxw.delete();
    done_n = 0;
  endtask
  // two words back to back, tx word repeated per word
  task automatic t_words();
    load(8'ha5);
    fork
      host.frame(16'h3cc3, 16, q);
      begin
        #400;
        chk(tx_ready, 1'b0);
        chk(frame_active, 1'b1);
      end
    join
    repeat (12) @(negedge i_clk);
    chk(16'(rxw.size()), 16'h0002);
    chk(rxw[0], 8'h3c);
    chk(rxw[1], 8'hc3);
    chk(q, 16'ha5a5);
    chk(word_cnt, 8'h02);
    chk(16'(done_n), 16'h0001);
    chk(pins_out.miso_oe, 1'b0);
    chk(frame_active, 1'b0);
    settle();
  endtask
  // aborted word must not shift the next frame
  task automatic t_partial();
    load(8'h96);
    host.frame(16'hf000, 5, q);
    host.frame(16'h5a00, 8, q);
    repeat (12) @(negedge i_clk);
    chk(16'(rxw.size()), 16'h0001);
    chk(rxw[0], 8'h5a);
    chk(q, 16'h0096);
    chk(word_cnt, 8'h01);
    settle();
  endtask
  task automatic t_deselect();
    host.noise();
    repeat (12) @(negedge i_clk);
    chk(16'(rxw.size()), 16'h0000);
    chk(word_cnt, 8'h01);
    chk(16'(done_n), 16'h0000);
    chk(frame_active, 1'b0);
  endtask

  task automatic test_done();
    if (error_cnt == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    tx_data = 8'h00;
    tx_valid = 1'b0;
    repeat (20) @(negedge i_clk);
    i_rst_n = 1'b1;
    chk(word_cnt, 8'h00);
    chk(frame_active, 1'b0);
    chk(pins_out.miso_oe, 1'b0);
    t_words();
    t_partial();
    t_deselect();
    test_done();
  end
  initial begin
    #100000;
    error_cnt++;
    test_done();
  end
endmodule // rsspi_slave_tb_top
